// ==== verilog/i2chc_host.sv ====
// Behaviour
// (RULE1) After a repeated start request, write data only once start is seen on bus.
// (RULE2) Both cancel bits set to 1 lift all the software timing restrictions.
// (RULE3) Issue stop only after clock reads low following the 9th clock rise; the code takes the first clock rise after the command, without counting clocks.
// (RULE4) In master wait mode clear the transfer flag only with clock low.
// (RULE5) Clearing the flag during stretched clock high may forge start or stop.
// (RULE6) Slave transmit: no data or control access in the restricted interval.
// (RULE7) Mode register bit counter reads 000 during 8th or 9th clock.
// (RULE8) Counter at zero: wait two transfer clock periods before the access.
// (RULE9) Slave direction write takes effect at once in the early window.
// (RULE10) Slave direction write elsewhere waits for 9th clock rise or stop.
// (RULE11) Repeated start without stop keeps transmit; no acknowledge for address.
// (RULE12) Clear direction select inside the immediate window to receive addresses.
// (RULE13) Release held clock: clear direction select, then dummy read data.
// (RULE14) Wrong direction data access may let clock pulses out too early.
// (RULE15) Read data only in receive direction, write only in transmit.
// (RULE16) Unhandled not-acknowledge may raise interrupt on a mismatched address.
// (RULE17) Slave transmit start or address may set flag despite mismatch.
// (RULE18) Clearing acknowledge check enable zeroes the received acknowledge bit.
// (RULE19) Select receive before the next start when leaving slave transmit.
// (RULE20) Device leaves reset in module stop; access only after cancelling it.
// (RULE21) Change mode bits only after the bus busy bit reads 0.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`default_nettype none
module i2chc_host #(
	parameter int TCLK_NS = 10000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [i2chc_pkg::SWA_W-1:0] sw_addr,
	input wire logic [i2chc_pkg::DW-1:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [i2chc_pkg::DW-1:0] sw_rdata,
	output logic [i2chc_pkg::DEVA_W-1:0] dev_addr,
	output logic [i2chc_pkg::DW-1:0] dev_wdata,
	output logic dev_wr,
	output logic dev_rd,
	input wire logic [i2chc_pkg::DW-1:0] dev_rdata,
	output logic dev_mstop,
	input wire logic scl_in,
	input wire logic sda_in
);
	import i2chc_pkg::*;

	localparam int DLY_CYC = (XFER_N * TCLK_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [CNT_W-1:0] DLY_LAST = CNT_W'(DLY_CYC - 1);

	i2chc_state_t st_q;
	i2chc_op_t op;
	logic [DEVA_W-1:0] op_adr;
	logic [DW-1:0] op_dat;
	logic [CMD_W-1:0] cmd_q;
	logic [STEP_W-1:0] step_q;
	logic [CNT_W-1:0] cnt_q;
	logic [DW-1:0] data_q, ctrl_q, mode_q, rx_q, last_rd_q;
	logic [DW-1:0] dev_wdata_q, sw_rdata_q;
	logic [DEVA_W-1:0] dev_addr_q;
	logic [1:0] cfg_q;
	logic [1:0] scl_sy_q, sda_sy_q;
	logic scl_p_q, sda_p_q, scl_s, sda_s;
	logic dev_wr_q, dev_rd_q, mstop_q;
	logic done_q, err_q, ph_q, start_seen_q, bc_ok_q;
	logic busy, cancel_on, is_wait, skip, cmd_go, cmd_bad;
	logic start_det, scl_rise, wait_ok, dly_end, stat_clr;

	// Pin synchronisers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_sy_q <= 2'h3;
			sda_sy_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_sy_q <= {scl_sy_q[0], scl_in};
			sda_sy_q <= {sda_sy_q[0], sda_in};
			scl_p_q <= scl_sy_q[1];
			sda_p_q <= sda_sy_q[1];
		end
	end

	assign scl_s = scl_sy_q[1];
	assign sda_s = sda_sy_q[1];
	assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign scl_rise = scl_s && !scl_p_q;
	assign busy = (st_q != ST_IDLE);
	assign cancel_on = (cfg_q == CANCEL_ALL); // RULE2
	assign cmd_bad = mstop_q && (sw_wdata[CMD_W-1:0] != CMD_INIT); // RULE20
	assign cmd_go = sw_wr && (sw_addr == SW_CMD) && !busy && !cmd_bad;
	assign stat_clr = sw_wr && (sw_addr == SW_STAT);

	// Command sequences
	always_comb begin
		op = OP_END;
		op_adr = ADR_CTRL;
		op_dat = ctrl_q;
		case (cmd_q)
			CMD_INIT: begin
				case (step_q)
					3'h0: op = OP_MSTP; // RULE20
					3'h1: begin
						op = OP_WR;
						op_adr = ADR_EXT;
						op_dat = {6'h00, cfg_q}; // RULE2
					end
					default: op = OP_END;
				endcase
			end
			CMD_RESTART: begin
				case (step_q)
					3'h0: begin
						op = OP_WR;
						op_dat = (ctrl_q | M_BUSY) & ~M_START_STOP;
					end
					3'h1: op = OP_WST; // RULE1
					3'h2: begin
						op = OP_WR;
						op_adr = ADR_DATA;
						op_dat = data_q;
					end
					default: op = OP_END;
				endcase
			end
			CMD_STOP: begin
				case (step_q)
					3'h0: op = OP_W9; // RULE3
					3'h1: begin
						op = OP_WR;
						op_dat = ctrl_q & ~(M_BUSY | M_START_STOP);
					end
					default: op = OP_END;
				endcase
			end
			CMD_CLRIRQ: begin
				case (step_q)
					3'h0: op = OP_WLO; // RULE4 RULE5
					3'h1: begin
						op = OP_WR;
						op_dat = ctrl_q & ~M_IRQ;
					end
					default: op = OP_END;
				endcase
			end
			CMD_SLVRD: begin
				case (step_q)
					3'h0: begin
						op = OP_PBC; // RULE6 RULE7
						op_adr = ADR_MODE;
					end
					3'h1: begin
						op = OP_WR;
						op_dat = ctrl_q & ~M_DIR; // RULE15
					end
					3'h2: begin
						op = OP_RD;
						op_adr = ADR_DATA;
					end
					default: op = OP_END;
				endcase
			end
			CMD_TX: begin
				case (step_q)
					3'h0: begin
						op = OP_WR;
						op_dat = ctrl_q | M_DIR; // RULE14 RULE15
					end
					3'h1: begin
						op = OP_WR;
						op_adr = ADR_DATA;
						op_dat = data_q;
					end
					default: op = OP_END;
				endcase
			end
			CMD_RELEASE: begin
				case (step_q)
					3'h0: begin
						op = OP_WR;
						op_dat = ctrl_q & ~M_DIR; // RULE12 RULE19
					end
					3'h1: begin
						op = OP_RD; // RULE13
						op_adr = ADR_DATA;
					end
					default: op = OP_END;
				endcase
			end
			CMD_ACKFIX: begin
				case (step_q)
					3'h0: begin
						op = OP_WR;
						op_dat = ctrl_q & ~M_ACK_CHK; // RULE18 RULE16 RULE17
					end
					3'h1: op = OP_WR;
					default: op = OP_END;
				endcase
			end
			CMD_MODE: begin
				case (step_q)
					3'h0: op = OP_PBSY; // RULE21
					3'h1: begin
						op = OP_WR;
						op_adr = ADR_MODE;
						op_dat = mode_q;
					end
					default: op = OP_END;
				endcase
			end
			default: op = OP_END;
		endcase
	end

	assign is_wait = (op == OP_WST) || (op == OP_W9) || (op == OP_WLO) || (op == OP_PBC) || (op == OP_PBSY);
	assign skip = is_wait && cancel_on; // RULE2
	assign wait_ok = ((op == OP_WST) && start_det) || ((op == OP_WLO) && !scl_s) || ((op == OP_W9) && ph_q && !scl_s);
	assign dly_end = (st_q == ST_DLY) && (cnt_q == DLY_LAST);

	// Sequencer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			cmd_q <= CMD_NONE;
			step_q <= '0;
			cnt_q <= '0;
			ph_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (cmd_go) begin
						cmd_q <= sw_wdata[CMD_W-1:0];
						step_q <= '0;
						st_q <= ST_DISP;
					end
				end
				ST_DISP: begin
					if (skip) begin
						step_q <= step_q + 3'h1;
					end else begin
						case (op)
							OP_WR, OP_MSTP: step_q <= step_q + 3'h1;
							OP_RD, OP_PBC, OP_PBSY: st_q <= ST_RSTB;
							OP_WST, OP_W9, OP_WLO: begin
								ph_q <= 1'b0;
								st_q <= ST_WAIT;
							end
							default: st_q <= ST_IDLE;
						endcase
					end
				end
				ST_RSTB: st_q <= ST_RCAP;
				ST_RCAP: begin
					if ((op == OP_PBSY) && dev_rdata[BIT_BUSY]) begin
						st_q <= ST_DISP; // RULE21
					end else if ((op == OP_PBC) && (dev_rdata[BC_W-1:0] == BC_ZERO)) begin
						cnt_q <= '0;
						st_q <= ST_DLY; // RULE8
					end else begin
						step_q <= step_q + 3'h1;
						st_q <= ST_DISP;
					end
				end
				ST_WAIT: begin
					if (scl_rise) begin
						ph_q <= 1'b1; // RULE3
					end
					if (wait_ok) begin
						step_q <= step_q + 3'h1;
						st_q <= ST_DISP;
					end
				end
				ST_DLY: begin
					cnt_q <= cnt_q + 16'h0001;
					if (dly_end) begin
						step_q <= step_q + 3'h1; // RULE8
						st_q <= ST_DISP;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Device register port
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dev_wr_q <= 1'b0;
			dev_rd_q <= 1'b0;
			dev_addr_q <= ADR_CTRL;
			dev_wdata_q <= RST_BYTE;
			mstop_q <= 1'b1; // RULE20
		end else begin
			dev_wr_q <= 1'b0;
			dev_rd_q <= 1'b0;
			if ((st_q == ST_DISP) && !skip) begin
				case (op)
					OP_WR: begin
						dev_wr_q <= 1'b1;
						dev_addr_q <= op_adr;
						dev_wdata_q <= op_dat;
					end
					OP_RD, OP_PBC, OP_PBSY: begin
						dev_rd_q <= 1'b1;
						dev_addr_q <= op_adr;
					end
					OP_MSTP: mstop_q <= 1'b0; // RULE20
					default: dev_wr_q <= 1'b0;
				endcase
			end
		end
	end

	// Read capture and guards
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			last_rd_q <= RST_BYTE;
			rx_q <= RST_BYTE;
			start_seen_q <= 1'b0;
			bc_ok_q <= 1'b0;
		end else begin
			if (st_q == ST_RCAP) begin
				last_rd_q <= dev_rdata;
				if (op == OP_RD) begin
					rx_q <= dev_rdata;
				end
			end
			if (start_det) begin
				start_seen_q <= 1'b1;
			end else if (cmd_go) begin
				start_seen_q <= 1'b0;
			end
			if (cmd_go) begin
				bc_ok_q <= 1'b0;
			end else if (dly_end || ((st_q == ST_RCAP) && (op == OP_PBC) && (dev_rdata[BC_W-1:0] != BC_ZERO))) begin
				bc_ok_q <= 1'b1;
			end
		end
	end

	// Own registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			data_q <= RST_BYTE;
			ctrl_q <= RST_BYTE;
			mode_q <= RST_BYTE;
			cfg_q <= 2'h0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			if (sw_wr && !busy) begin
				case (sw_addr)
					SW_DATA: data_q <= sw_wdata;
					SW_CTRL: ctrl_q <= sw_wdata;
					SW_MODE: mode_q <= sw_wdata;
					SW_CFG: cfg_q <= sw_wdata[1:0];
					default: cfg_q <= cfg_q;
				endcase
			end
			done_q <= ((st_q == ST_DISP) && !skip && (op == OP_END)) || (done_q && !stat_clr);
			err_q <= (sw_wr && (sw_addr == SW_CMD) && (busy || cmd_bad)) || (err_q && !stat_clr);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sw_rdata_q <= RST_BYTE;
		end else if (sw_rd) begin
			case (sw_addr)
				SW_CMD: sw_rdata_q <= {4'h0, cmd_q};
				SW_DATA: sw_rdata_q <= data_q;
				SW_CTRL: sw_rdata_q <= ctrl_q;
				SW_CFG: sw_rdata_q <= {6'h00, cfg_q};
				SW_STAT: sw_rdata_q <= {2'h0, sda_s, scl_s, mstop_q, err_q, done_q, busy};
				SW_MODE: sw_rdata_q <= mode_q;
				SW_RX: sw_rdata_q <= rx_q;
				default: sw_rdata_q <= RST_BYTE;
			endcase
		end else begin
			sw_rdata_q <= RST_BYTE;
		end
	end

	assign sw_rdata = sw_rdata_q;
	assign dev_addr = dev_addr_q;
	assign dev_wdata = dev_wdata_q;
	assign dev_wr = dev_wr_q;
	assign dev_rd = dev_rd_q;
	assign dev_mstop = mstop_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_start_before_data: assert property ( // RULE1
		(dev_wr_q && dev_addr_q == ADR_DATA && cmd_q == CMD_RESTART) |-> (start_seen_q || cancel_on))
		else $error("data written before repeated start seen");
	a_cancel_no_wait: assert property ( // RULE2
		cancel_on |-> !$rose(st_q == ST_WAIT) && !$rose(st_q == ST_DLY))
		else $error("waited although restrictions cancelled");
	a_stop_scl_low: assert property ( // RULE3
		(dev_wr_q && cmd_q == CMD_STOP) |-> (cancel_on || !$past(scl_s, 2)))
		else $error("stop issued with clock high");
	a_clrirq_scl_low: assert property ( // RULE4
		(dev_wr_q && cmd_q == CMD_CLRIRQ) |-> (cancel_on || !$past(scl_s, 2)))
		else $error("flag cleared with clock high");
	a_slvrd_spacing: assert property ( // RULE8
		(dev_rd_q && dev_addr_q == ADR_DATA && cmd_q == CMD_SLVRD) |-> (bc_ok_q || cancel_on))
		else $error("slave read inside restricted interval");
	a_dly_bound: assert property ( // RULE8
		$rose(st_q == ST_DLY) |-> (st_q == ST_DLY) [*8])
		else $error("delay ended too early");
	a_tx_dir_first: assert property ( // RULE15
		(dev_wr_q && dev_addr_q == ADR_DATA && cmd_q == CMD_TX) |->
		($past(dev_wr_q) && $past(dev_addr_q) == ADR_CTRL && $past(dev_wdata_q[BIT_DIR])))
		else $error("data written before transmit direction");
	a_release_order: assert property ( // RULE13
		(dev_rd_q && cmd_q == CMD_RELEASE) |-> ($past(dev_wr_q) && !$past(dev_wdata_q[BIT_DIR])))
		else $error("dummy read without direction clear");
	a_ackfix_pulse: assert property ( // RULE18
		(dev_wr_q && cmd_q == CMD_ACKFIX && step_q == 3'h1 && !dev_wdata_q[BIT_ACK_CHK]) |=>
		(dev_wr_q && dev_wdata_q[BIT_ACK_CHK] == ctrl_q[BIT_ACK_CHK]))
		else $error("acknowledge check not restored");
	a_mode_after_idle: assert property ( // RULE21
		(dev_wr_q && dev_addr_q == ADR_MODE) |-> (cancel_on || !last_rd_q[BIT_BUSY]))
		else $error("mode changed while bus busy");
	a_mstop_access: assert property ( // RULE20
		mstop_q |-> !dev_wr_q && !dev_rd_q)
		else $error("device accessed in module stop");
	a_strobe_excl: assert property (
		!(dev_wr_q && dev_rd_q))
		else $error("device strobes overlap");

	c_restart: cover property (dev_wr_q && dev_addr_q == ADR_DATA && cmd_q == CMD_RESTART);
	c_stop: cover property (dev_wr_q && cmd_q == CMD_STOP && !cancel_on);
	c_slvrd_dly: cover property (dly_end && cmd_q == CMD_SLVRD);
	c_mode_poll: cover property ((st_q == ST_RCAP) && (op == OP_PBSY) ##[1:20] dev_wr_q);
endmodule // i2chc_host
`default_nettype wire

// ==== verilog/i2chc_pkg.sv ====
`default_nettype none
package i2chc_pkg;
	localparam int DW = 8;
	localparam int SWA_W = 3;
	localparam int DEVA_W = 2;
	localparam int CMD_W = 4;
	localparam int STEP_W = 3;
	localparam int CNT_W = 16;
	localparam int CLK_NS = 5;
	localparam int XFER_N = 2;
	// Own register offsets
	localparam logic [SWA_W-1:0] SW_CMD = 3'h0;
	localparam logic [SWA_W-1:0] SW_DATA = 3'h1;
	localparam logic [SWA_W-1:0] SW_CTRL = 3'h2;
	localparam logic [SWA_W-1:0] SW_CFG = 3'h3;
	localparam logic [SWA_W-1:0] SW_STAT = 3'h4;
	localparam logic [SWA_W-1:0] SW_MODE = 3'h5;
	localparam logic [SWA_W-1:0] SW_RX = 3'h6;
	// Device register offsets
	localparam logic [DEVA_W-1:0] ADR_CTRL = 2'h0;
	localparam logic [DEVA_W-1:0] ADR_DATA = 2'h1;
	localparam logic [DEVA_W-1:0] ADR_MODE = 2'h2;
	localparam logic [DEVA_W-1:0] ADR_EXT = 2'h3;
	// Control register fields
	localparam int BIT_BUSY = 7;
	localparam int BIT_DIR = 4;
	localparam int BIT_ACK_CHK = 1;
	localparam logic [DW-1:0] M_BUSY = 8'h80;
	localparam logic [DW-1:0] M_START_STOP = 8'h40;
	localparam logic [DW-1:0] M_DIR = 8'h10;
	localparam logic [DW-1:0] M_ACK_CHK = 8'h02;
	localparam logic [DW-1:0] M_IRQ = 8'h01;
	localparam int BC_W = 3;
	localparam logic [BC_W-1:0] BC_ZERO = 3'h0;
	localparam logic [1:0] CANCEL_ALL = 2'h3;
	localparam int ST_DONE = 1;
	localparam logic [DW-1:0] RST_BYTE = 8'h00;
	localparam logic [CMD_W-1:0] CMD_NONE = 4'h0;
	localparam logic [CMD_W-1:0] CMD_INIT = 4'h1;
	localparam logic [CMD_W-1:0] CMD_RESTART = 4'h2;
	localparam logic [CMD_W-1:0] CMD_STOP = 4'h3;
	localparam logic [CMD_W-1:0] CMD_CLRIRQ = 4'h4;
	localparam logic [CMD_W-1:0] CMD_SLVRD = 4'h5;
	localparam logic [CMD_W-1:0] CMD_TX = 4'h6;
	localparam logic [CMD_W-1:0] CMD_RELEASE = 4'h7;
	localparam logic [CMD_W-1:0] CMD_ACKFIX = 4'h8;
	localparam logic [CMD_W-1:0] CMD_MODE = 4'h9;
	typedef enum logic [3:0] {
		OP_END, OP_WR, OP_RD, OP_MSTP, OP_WST, OP_W9, OP_WLO, OP_PBC, OP_PBSY
	} i2chc_op_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DISP = 6'h02,
		ST_RSTB = 6'h04,
		ST_RCAP = 6'h08,
		ST_WAIT = 6'h10,
		ST_DLY = 6'h20
	} i2chc_state_t;
endpackage // i2chc_pkg
`default_nettype wire

// ==== test/i2chc_dev_model.sv ====
`default_nettype none
module i2chc_dev_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [i2chc_pkg::DEVA_W-1:0] dev_addr,
	input wire logic [i2chc_pkg::DW-1:0] dev_wdata,
	input wire logic dev_wr,
	input wire logic dev_rd,
	output logic [i2chc_pkg::DW-1:0] dev_rdata,
	input wire logic dev_mstop,
	input wire logic bus_busy,
	input wire logic [i2chc_pkg::BC_W-1:0] bit_count,
	input wire logic nack,
	output logic received_ack_bit,
	output logic dir_err
);
	timeunit 1ns;
	timeprecision 100ps;
	import i2chc_pkg::*;
	logic [DW-1:0] ctrl_q, data_q, mode_q, ext_q;
	// Register writes, ignored while stopped
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= RST_BYTE;
			data_q <= RST_BYTE;
			mode_q <= RST_BYTE;
			ext_q <= RST_BYTE;
			received_ack_bit <= 1'b0;
		end else begin
			if (dev_wr && !dev_mstop) begin
				case (dev_addr)
					ADR_CTRL: begin
						ctrl_q <= dev_wdata;
						if (!dev_wdata[BIT_ACK_CHK])
							received_ack_bit <= 1'b0;
					end
					ADR_DATA: data_q <= dev_wdata;
					ADR_MODE: mode_q <= dev_wdata;
					default: ext_q <= dev_wdata;
				endcase
			end
			if (nack)
				received_ack_bit <= 1'b1;
		end
	end
	// Data buffer access against the selected direction
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			dir_err <= 1'b0;
		else if (!dev_mstop && (dev_addr == ADR_DATA) && ((dev_rd && ctrl_q[BIT_DIR]) || (dev_wr && !ctrl_q[BIT_DIR])))
			dir_err <= 1'b1;
	end
	// Read data stands one cycle, otherwise a changing pattern
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			dev_rdata <= RST_BYTE;
		else if (dev_rd && !dev_mstop) begin
			case (dev_addr)
				ADR_CTRL: dev_rdata <= {bus_busy, ctrl_q[6:0]};
				ADR_DATA: dev_rdata <= data_q;
				ADR_MODE: dev_rdata <= {mode_q[7:3], bit_count};
				default: dev_rdata <= ext_q;
			endcase
		end else
			dev_rdata <= ~dev_rdata;
	end
endmodule // i2chc_dev_model
`default_nettype wire

// ==== test/test_i2chc_host.sv ====
`default_nettype none
module test_i2chc_host;
	timeunit 1ns;
	timeprecision 100ps;
	import i2chc_pkg::*;
	localparam int TCLK = 100;
	localparam int DLY = 2 * TCLK / CLK_NS;
	logic sys_clk, rst, sw_wr, sw_rd, dev_wr, dev_rd, dev_mstop, scl_in, sda_in, bus_busy, nack;
	logic received_ack_bit, dir_err;
	logic [SWA_W-1:0] sw_addr;
	logic [DW-1:0] sw_wdata, sw_rdata, dev_wdata, dev_rdata, c_val, d_val, rd;
	logic [DEVA_W-1:0] dev_addr;
	logic [BC_W-1:0] bit_count;
	logic [DW+DEVA_W-1:0] wq[$];
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;

	i2chc_host #(.TCLK_NS(TCLK)) dut (.sys_clk, .rst, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
		.dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata, .dev_mstop, .scl_in, .sda_in);
	i2chc_dev_model model (.sys_clk, .rst, .dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata,
		.dev_mstop, .bus_busy, .bit_count, .nack, .received_ack_bit, .dir_err);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Device writes compared in order with the expected queue
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
		if (dev_wr) begin
			if (wq.size() == 0)
				check("unexpected dev write", 16'hffff, {6'h0, dev_addr, dev_wdata});
			else
				check("dev write", {6'h0, wq.pop_front()}, {6'h0, dev_addr, dev_wdata});
		end
	end

	task automatic sw_write(input logic [SWA_W-1:0] a, input logic [DW-1:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask

	task automatic sw_read(input logic [SWA_W-1:0] a, output logic [DW-1:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		@(posedge sys_clk);
		d = sw_rdata;
	endtask

	task automatic cmd(input logic [CMD_W-1:0] c);
		sw_write(SW_STAT, 8'h00);
		sw_write(SW_CMD, {4'h0, c});
	endtask

	task automatic finish_cmd(input logic [2:0] st);
		for (int n = 0; n < 100; n++) begin
			sw_read(SW_STAT, rd);
			if (rd[0] === 1'b0)
				break;
		end
		check("status", {13'h0, st}, {13'h0, rd[2:0]});
		check("writes left", 16'h0, 16'(wq.size()));
		wq.delete();
	endtask

	initial begin
		rst = 1'b1;
		sw_addr = 3'h0;
		sw_wdata = 8'h00;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		scl_in = 1'b0;
		sda_in = 1'b1;
		bus_busy = 1'b0;
		bit_count = 3'h1;
		nack = 1'b0;
		void'($urandom(32'h3f4c));
		c_val = 8'($urandom()) | M_ACK_CHK | M_DIR;
		d_val = 8'($urandom());
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1 check("mstop", 16'h1, {15'h0, dev_mstop});
		cmd(CMD_CLRIRQ);
		finish_cmd(3'b100);
		sw_write(SW_CFG, 8'h00);
		wq.push_back({ADR_EXT, 8'h00});
		cmd(CMD_INIT);
		finish_cmd(3'b010);
		check("mstop", 16'h0, {15'h0, dev_mstop});
		sw_write(SW_CTRL, c_val);
		sw_write(SW_DATA, d_val);
		wq.push_back({ADR_CTRL, c_val | M_DIR});
		wq.push_back({ADR_DATA, d_val});
		cmd(CMD_TX);
		finish_cmd(3'b010);
		nack <= 1'b1;
		@(posedge sys_clk);
		nack <= 1'b0;
		wq.push_back({ADR_CTRL, c_val & ~M_ACK_CHK});
		wq.push_back({ADR_CTRL, c_val});
		cmd(CMD_ACKFIX);
		finish_cmd(3'b010);
		check("ack bit", 16'h0, {15'h0, received_ack_bit});
		wq.push_back({ADR_CTRL, c_val & ~M_DIR});
		cmd(CMD_RELEASE);
		finish_cmd(3'b010);
		sw_read(SW_RX, rd);
		check("dummy read", {8'h0, d_val}, {8'h0, rd});
		scl_in <= 1'b1;
		wq.push_back({ADR_CTRL, (c_val | M_BUSY) & ~M_START_STOP});
		cmd(CMD_RESTART);
		repeat (10) @(posedge sys_clk);
		wq.push_back({ADR_DATA, d_val});
		sda_in <= 1'b0;
		finish_cmd(3'b010);
		scl_in <= 1'b0;
		@(posedge sys_clk);
		sda_in <= 1'b1;
		cmd(CMD_STOP);
		repeat (8) @(posedge sys_clk);
		sw_write(SW_CMD, {4'h0, CMD_TX});
		scl_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		wq.push_back({ADR_CTRL, c_val & ~(M_BUSY | M_START_STOP)});
		scl_in <= 1'b0;
		finish_cmd(3'b110);
		scl_in <= 1'b1;
		cmd(CMD_CLRIRQ);
		repeat (8) @(posedge sys_clk);
		wq.push_back({ADR_CTRL, c_val & ~M_IRQ});
		scl_in <= 1'b0;
		finish_cmd(3'b010);
		for (int i = 0; i < 2; i++) begin
			bit_count <= (i == 0) ? BC_ZERO : 3'h5;
			cmd(CMD_SLVRD);
			if (i == 0)
				repeat (DLY - 8) @(posedge sys_clk);
			wq.push_back({ADR_CTRL, c_val & ~M_DIR});
			finish_cmd(3'b010);
			sw_read(SW_RX, rd);
			check("slave rx", {8'h0, d_val}, {8'h0, rd});
		end
		bus_busy <= 1'b1;
		sw_write(SW_MODE, d_val);
		cmd(CMD_MODE);
		repeat (20) @(posedge sys_clk);
		wq.push_back({ADR_MODE, d_val});
		bus_busy <= 1'b0;
		finish_cmd(3'b010);
		sw_write(3'h7, ~d_val);
		sw_read(SW_DATA, rd);
		check("data reg", {8'h0, d_val}, {8'h0, rd});
		sw_write(SW_CFG, {6'h0, CANCEL_ALL});
		wq.push_back({ADR_EXT, {6'h0, CANCEL_ALL}});
		cmd(CMD_INIT);
		finish_cmd(3'b010);
		wq.push_back({ADR_CTRL, c_val & ~(M_BUSY | M_START_STOP)});
		cmd(CMD_STOP);
		finish_cmd(3'b010);
		cmd(4'hf);
		finish_cmd(3'b010);
		check("wrong direction", 16'h0, {15'h0, dir_err});
		summarize();
	end
endmodule // test_i2chc_host
`default_nettype wire
